// ### hw/radio_spi_fifo_table_pin_control.sv
// Serial port access to the data queues and power table, shared pins and pin control
//
// How it works
// - Address 0x3f reaches transmit queue on write, receive queue on read.
// - Queue headers: 0x3f, 0x7f single/burst write; 0xbf, 0xff single/burst read.
// - Every data byte written to transmit queue returns a status byte.
// - Status free count is taken after the incoming byte is stored.
// - In idle or an error state, transmit flush empties transmit queue; receive flush empties receive queue.
// - Entering sleep empties both queues.
// - Power table sits at address 0x3e and takes up to eight bytes.
// - Table has eight byte entries, chosen by a 3-bit level select.
// - Table index steps per byte, wraps 7 to 0, clears while select high.
// - Table access is single or burst, read or write, from header bits.
// - Sleep wipes all table entries except entry zero.
// - Shared pin floats by default, generic when enabled, serial out while selected.
// - In serial modes during transmit, general pin 0 is transmit data input.
// - Three-pin state control works only when its enable bit is set.
// - Pins set while select high are latched on select falling edge.
// - Clock,data 00 power-down, 01 transmit, 10 idle, 11 receive.
// - Pin commands only change state; same-state command does nothing.
// - Pin strobes act at once, except power-down waits for select high.
// - Select low gives normal serial port and wakes sleep into idle.
// - Status state reads 110 after overflow, 111 after underflow, until flushed or changed by a pin command.
// - Burst header loads address counter, incremented after each byte.
`timescale 1ns/1ps
`default_nettype none
module radio_spi_fifo_table_pin_control
   import radio_spi_pkg::*;
(
   input  wire logic                    ref_clk,
   input  wire logic                    rst_n,
   input  wire logic                    chip_select_n,
   input  wire logic                    serial_clk,
   input  wire logic                    serial_data_in,
   output var  logic                    gp_output_1_shared_out,
   output var  logic                    gp_output_1_shared_oe,
   input  wire logic                    gp_output_0_in,
   output var  logic                    gp_output_0_out,
   output var  logic                    gp_output_0_oe,
   input  wire logic                    pin_ctrl_en,
   input  wire logic                    shared_pin_generic_en,
   input  wire logic                    serial_mode_en,
   input  wire logic [TABLE_IDX_W-1:0]  pa_level_select,
   output var  logic [BYTE_BITS-1:0]    pa_setting,
   output var  logic [2:0]              radio_state,
   output var  logic                    serial_tx_bit,
   output var  logic                    tx_out_valid,
   output var  logic [BYTE_BITS-1:0]    tx_out_data,
   input  wire logic                    tx_out_ready,
   input  wire logic                    rx_in_valid,
   input  wire logic [BYTE_BITS-1:0]    rx_in_data,
   output var  logic                    rx_in_ready
);
   import radio_spi_pkg::*;

   // Pin synchronisers: bit 0 select, 1 clock, 2 data in, 3 general pin 0
   logic [3:0]            sync1_reg, sync2_reg, prev_reg;
   logic                  cs_low, cs_fall, cs_rise, clk_rise, clk_fall, si_s;

   // Serial engine state
   logic [2:0]            bit_cnt_reg, bit_cnt_next;
   logic [7:0]            in_shift_reg, in_shift_next;
   logic [7:0]            out_shift_reg, out_shift_next;
   logic [7:0]            hdr_reg, hdr_next;
   logic                  hdr_seen_reg, hdr_seen_next;
   logic [5:0]            addr_cnt_reg, addr_cnt_next;
   logic [2:0]            tbl_idx_reg, tbl_idx_next;
   logic [7:0]            table_reg [TABLE_DEPTH];
   logic [7:0]            table_next [TABLE_DEPTH];

   // Radio state
   radio_state_type       state_reg, state_next;
   logic                  pd_pending_reg, pd_pending_next;
   logic [1:0]            tx_held_reg, tx_held_next;

   // Pin-facing registered outputs
   logic                  so_out_reg, so_out_next, so_oe_reg, so_oe_next;
   logic                  gp0_out_reg, gp0_out_next, gp0_oe_reg, gp0_oe_next;
   logic                  ser_bit_reg, ser_bit_next;
   logic [7:0]            pa_reg, pa_next;
   logic [2:0]            code_reg;

   // Per-cycle decode
   logic [7:0]            byte_in;
   logic [5:0]            target;
   logic                  is_read, is_burst, byte_done;
   logic                  tx_push, rx_pop, flush_tx, flush_rx, go_sleep, flush_ok;
   logic [QUEUE_CNT_W-1:0] tx_free;

   queue_if tx_q ();
   queue_if rx_q ();

   logic                  tx_skid_ready;
   logic                  rx_skid_valid;
   logic [7:0]            rx_skid_data;

   byte_queue #(.DEPTH(QUEUE_DEPTH)) tx_queue (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .q       (tx_q)
   );

   byte_queue #(.DEPTH(QUEUE_DEPTH)) rx_queue (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .q       (rx_q)
   );

   // Radio side drains the transmit queue through a two-entry buffer
   skid_buffer #(.WIDTH(BYTE_BITS)) tx_skid (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .flush     (tx_q.clear),
      .in_valid  (!tx_q.empty),
      .in_data   (tx_q.head),
      .in_ready  (tx_skid_ready),
      .out_valid (tx_out_valid),
      .out_data  (tx_out_data),
      .out_ready (tx_out_ready)
   );

   // Receiver fills the receive queue through a second buffer; ready falls when full
   skid_buffer #(.WIDTH(BYTE_BITS)) rx_skid (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .flush     (rx_q.clear),
      .in_valid  (rx_in_valid),
      .in_data   (rx_in_data),
      .in_ready  (rx_in_ready),
      .out_valid (rx_skid_valid),
      .out_data  (rx_skid_data),
      .out_ready (!rx_q.full)
   );

   assign tx_q.push      = tx_push;
   assign tx_q.push_data = byte_in;
   assign tx_q.pop       = !tx_q.empty && tx_skid_ready;
   assign tx_q.clear     = flush_tx || go_sleep;
   assign rx_q.push      = rx_skid_valid;
   assign rx_q.push_data = rx_skid_data;
   assign rx_q.pop       = rx_pop;
   assign rx_q.clear     = flush_rx || go_sleep;

   assign gp_output_1_shared_out = so_out_reg;
   assign gp_output_1_shared_oe  = so_oe_reg;
   assign gp_output_0_out        = gp0_out_reg;
   assign gp_output_0_oe         = gp0_oe_reg;
   assign serial_tx_bit          = ser_bit_reg;
   assign pa_setting             = pa_reg;
   assign radio_state            = code_reg;

   // Edges are found on the second stage; the first stage feeds nothing else
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_reg <= PINS_RESET;
         sync2_reg <= PINS_RESET;
         prev_reg  <= PINS_RESET;
      end else begin
         sync1_reg <= {gp_output_0_in, serial_data_in, serial_clk, chip_select_n};
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
      end
   end

   always_comb begin
      cs_low   = !sync2_reg[0];
      cs_fall  = prev_reg[0] && !sync2_reg[0];
      cs_rise  = !prev_reg[0] && sync2_reg[0];
      clk_rise = !prev_reg[1] && sync2_reg[1];
      clk_fall = prev_reg[1] && !sync2_reg[1];
      si_s     = sync2_reg[2];
      byte_in  = {in_shift_reg[6:0], si_s};
      byte_done = cs_low && !cs_fall && clk_rise && (bit_cnt_reg == 3'h7);
   end

   // Serial engine
   always_comb begin
      bit_cnt_next   = bit_cnt_reg;
      in_shift_next  = in_shift_reg;
      out_shift_next = out_shift_reg;
      hdr_next       = hdr_reg;
      hdr_seen_next  = hdr_seen_reg;
      addr_cnt_next  = addr_cnt_reg;
      tbl_idx_next   = tbl_idx_reg;
      table_next     = table_reg;
      tx_push        = 1'b0;
      rx_pop         = 1'b0;
      flush_tx       = 1'b0;
      flush_rx       = 1'b0;
      go_sleep       = cs_rise && pd_pending_reg;
      flush_ok       = (state_reg == rs_idle) || (state_reg == rs_tx_underflow) ||
                       (state_reg == rs_rx_overflow);
      tx_free        = QUEUE_CNT_W'(QUEUE_DEPTH - tx_q.count - tx_held_reg);
      is_read        = hdr_reg[HDR_RW_BIT];
      is_burst       = hdr_reg[HDR_BURST_BIT];
      target         = hdr_reg[5:0];

      if (!cs_low) begin
         bit_cnt_next  = 3'h0;
         hdr_seen_next = 1'b0;
         tbl_idx_next  = 3'h0;
      end else if (cs_fall) begin
         out_shift_next = status_byte(state_reg, tx_free);
      end else if (clk_rise) begin
         in_shift_next = byte_in;
         bit_cnt_next  = 3'(bit_cnt_reg + 1'b1);
      end else if (clk_fall && bit_cnt_reg != 3'h0) begin
         out_shift_next = {out_shift_reg[6:0], 1'b0};
      end

      if (byte_done && !hdr_seen_reg) begin
         hdr_next      = byte_in;
         addr_cnt_next = byte_in[5:0];
         is_read       = byte_in[HDR_RW_BIT];
         is_burst      = byte_in[HDR_BURST_BIT];
         target        = byte_in[5:0];
         hdr_seen_next = (target == ADDR_QUEUE) || (target == ADDR_TABLE) || is_burst;
         if (!is_burst && flush_ok && target == ADDR_FLUSH_TX) flush_tx = 1'b1;
         if (!is_burst && flush_ok && target == ADDR_FLUSH_RX) flush_rx = 1'b1;
      end else if (byte_done) begin
         addr_cnt_next = 6'(addr_cnt_reg + 1'b1);
         hdr_seen_next = is_burst;
         if (target == ADDR_QUEUE && !is_read && tx_free != '0) tx_push = 1'b1;
         if (target == ADDR_TABLE) begin
            tbl_idx_next = 3'(tbl_idx_reg + 1'b1);
            if (!is_read) table_next[tbl_idx_reg] = byte_in;
         end
      end

      if (byte_done) begin
         out_shift_next = status_byte(state_reg, QUEUE_CNT_W'(tx_free - tx_push));
         if (hdr_seen_next && is_read && target == ADDR_QUEUE && !rx_q.empty) begin
            out_shift_next = rx_q.head;
            rx_pop         = 1'b1;
         end else if (hdr_seen_next && is_read && target == ADDR_TABLE) begin
            out_shift_next = table_reg[tbl_idx_next];
         end else if (hdr_seen_next && is_read) begin
            out_shift_next = 8'h00;
         end
      end

      if (go_sleep) begin
         for (int i = 1; i < TABLE_DEPTH; i++) table_next[i] = TABLE_RESET;
      end
   end

   // Radio state and pin control
   always_comb begin
      state_next      = state_reg;
      pd_pending_next = pd_pending_reg;
      // Buffered bytes still fill the queue
      tx_held_next    = tx_q.clear ? 2'h0 :
                        2'(tx_held_reg + tx_q.pop - (tx_out_valid && tx_out_ready));
      // select low wakes sleep into idle
      if (cs_fall && state_reg == rs_sleep) state_next = rs_idle;
      // latched from values held while high
      if (cs_fall && pin_ctrl_en) begin
         case ({prev_reg[1], prev_reg[2]})
            2'b00:   pd_pending_next = 1'b1;
            2'b01:   if (state_reg != rs_tx) state_next = rs_tx;
            2'b10:   state_next = rs_idle;
            2'b11:   if (state_reg != rs_rx) state_next = rs_rx;
            default: state_next = state_reg;
         endcase
      end
      // error states hold until their flush or a pin command
      if (state_reg == rs_tx && tx_out_ready && !tx_out_valid && tx_q.empty)
         state_next = rs_tx_underflow;
      if (state_reg == rs_rx && rx_in_valid && !rx_in_ready) state_next = rs_rx_overflow;
      if (flush_tx && state_reg == rs_tx_underflow) state_next = rs_idle;
      if (flush_rx && state_reg == rs_rx_overflow) state_next = rs_idle;
      // sleep entry, queues flushed by go_sleep
      if (go_sleep) begin
         state_next      = rs_sleep;
         pd_pending_next = 1'b0;
      end
   end

   // Shared and general pins
   always_comb begin
      // serial out while selected, else generic or floating
      so_oe_next   = cs_low || shared_pin_generic_en;
      so_out_next  = cs_low ? out_shift_next[7] : !rx_q.empty;
      gp0_oe_next  = 1'b1;
      gp0_out_next = (state_reg == rs_tx);
      ser_bit_next = ser_bit_reg;
      // general pin 0 becomes transmit data input
      if (serial_mode_en && state_reg == rs_tx) begin
         gp0_oe_next  = 1'b0;
         ser_bit_next = sync2_reg[3];
      end
      pa_next = table_reg[pa_level_select];
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt_reg    <= 3'h0;
         in_shift_reg   <= 8'h00;
         out_shift_reg  <= 8'h00;
         hdr_reg        <= 8'h00;
         hdr_seen_reg   <= 1'b0;
         addr_cnt_reg   <= 6'h00;
         tbl_idx_reg    <= 3'h0;
         for (int i = 0; i < TABLE_DEPTH; i++) table_reg[i] <= TABLE_RESET;
         state_reg      <= rs_idle;
         pd_pending_reg <= 1'b0;
         tx_held_reg    <= 2'h0;
         so_out_reg     <= 1'b0;
         so_oe_reg      <= 1'b0;
         gp0_out_reg    <= 1'b0;
         gp0_oe_reg     <= 1'b0;
         ser_bit_reg    <= 1'b0;
         pa_reg         <= TABLE_RESET;
         code_reg       <= CODE_IDLE;
      end else begin
         bit_cnt_reg    <= bit_cnt_next;
         in_shift_reg   <= in_shift_next;
         out_shift_reg  <= out_shift_next;
         hdr_reg        <= hdr_next;
         hdr_seen_reg   <= hdr_seen_next;
         addr_cnt_reg   <= addr_cnt_next;
         tbl_idx_reg    <= tbl_idx_next;
         table_reg      <= table_next;
         state_reg      <= state_next;
         pd_pending_reg <= pd_pending_next;
         tx_held_reg    <= tx_held_next;
         so_out_reg     <= so_out_next;
         so_oe_reg      <= so_oe_next;
         gp0_out_reg    <= gp0_out_next;
         gp0_oe_reg     <= gp0_oe_next;
         ser_bit_reg    <= ser_bit_next;
         pa_reg         <= pa_next;
         code_reg       <= state_code(state_next);
      end
   end
endmodule
`default_nettype wire

// ### hw/radio_spi_pkg.sv
// Shared constants, types and helpers of the serial port, queue and table logic
package radio_spi_pkg;

   localparam int          BYTE_BITS    = 8;
   localparam int          QUEUE_DEPTH  = 64;
   localparam int          QUEUE_CNT_W  = 7;
   localparam int          TABLE_DEPTH  = 8;
   localparam int          TABLE_IDX_W  = 3;

   // Header byte layout
   localparam int          HDR_RW_BIT    = 7;
   localparam int          HDR_BURST_BIT = 6;

   // Six-bit addresses
   localparam logic [5:0]  ADDR_TABLE    = 6'h3e;
   localparam logic [5:0]  ADDR_QUEUE    = 6'h3f;
   localparam logic [5:0]  ADDR_FLUSH_RX = 6'h30;
   localparam logic [5:0]  ADDR_FLUSH_TX = 6'h31;

   // Status byte state field codes
   localparam logic [2:0]  CODE_IDLE      = 3'h0;
   localparam logic [2:0]  CODE_RX        = 3'h1;
   localparam logic [2:0]  CODE_TX        = 3'h2;
   localparam logic [2:0]  CODE_OVERFLOW  = 3'h6;
   localparam logic [2:0]  CODE_UNDERFLOW = 3'h7;
   localparam logic [3:0]  COUNT_MAX      = 4'hf;

   // Reset values
   localparam logic [7:0]  TABLE_RESET    = 8'h00;
   localparam logic [3:0]  PINS_RESET     = 4'h1;

   typedef enum logic [2:0] {
      rs_sleep,
      rs_idle,
      rs_rx,
      rs_tx,
      rs_rx_overflow,
      rs_tx_underflow
   } radio_state_type;

   function automatic logic [2:0] state_code(input radio_state_type st);
      case (st)
         rs_rx:           state_code = CODE_RX;
         rs_tx:           state_code = CODE_TX;
         rs_rx_overflow:  state_code = CODE_OVERFLOW;
         rs_tx_underflow: state_code = CODE_UNDERFLOW;
         default:         state_code = CODE_IDLE;
      endcase
   endfunction

   // Byte count clipped to the four-bit status field
   function automatic logic [7:0] status_byte(input radio_state_type st,
                                              input logic [QUEUE_CNT_W-1:0] cnt);
      logic [3:0] clipped;
      clipped = (cnt > QUEUE_CNT_W'(COUNT_MAX)) ? COUNT_MAX : cnt[3:0];
      status_byte = {1'b0, state_code(st), clipped};
   endfunction

endpackage

// ### hw/queue_if.sv
// Connection bundle between a byte queue and the logic that fills and drains it
`timescale 1ns/1ps
`default_nettype none
interface queue_if;
   import radio_spi_pkg::*;
   logic                   push;
   logic [BYTE_BITS-1:0]   push_data;
   logic                   pop;
   logic                   clear;
   logic [BYTE_BITS-1:0]   head;
   logic [QUEUE_CNT_W-1:0] count;
   logic                   full;
   logic                   empty;
   modport owner (input push, push_data, pop, clear, output head, count, full, empty);
   modport user  (output push, push_data, pop, clear, input head, count, full, empty);
endinterface
`default_nettype wire

// ### hw/byte_queue.sv
// Flip-flop byte queue with push, pop, clear and occupancy count
`timescale 1ns/1ps
`default_nettype none
module byte_queue
   import radio_spi_pkg::*;
#(
   parameter int DEPTH = QUEUE_DEPTH
) (
   input  wire logic ref_clk,
   input  wire logic rst_n,
   queue_if.owner    q
);
   localparam int PW = $clog2(DEPTH);

   logic [BYTE_BITS-1:0]   mem_reg [DEPTH];
   logic [PW-1:0]          wr_reg, wr_next;
   logic [PW-1:0]          rd_reg, rd_next;
   logic [QUEUE_CNT_W-1:0] cnt_reg, cnt_next;
   logic                   do_push;
   logic                   do_pop;

   assign q.head  = mem_reg[rd_reg];
   assign q.count = cnt_reg;
   assign q.full  = (cnt_reg == QUEUE_CNT_W'(DEPTH));
   assign q.empty = (cnt_reg == '0);

   always_comb begin
      do_push  = q.push && !q.full && !q.clear;
      do_pop   = q.pop && !q.empty && !q.clear;
      wr_next  = wr_reg;
      rd_next  = rd_reg;
      cnt_next = cnt_reg;
      if (q.clear) begin
         wr_next  = '0;
         rd_next  = '0;
         cnt_next = '0;
      end else begin
         if (do_push) wr_next = PW'(wr_reg + 1'b1);
         if (do_pop) rd_next = PW'(rd_reg + 1'b1);
         cnt_next = QUEUE_CNT_W'(cnt_reg + do_push - do_pop);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         wr_reg  <= wr_next;
         rd_reg  <= rd_next;
         cnt_reg <= cnt_next;
      end
   end

   // Storage carries no reset; emptiness is tracked by the count alone
   always_ff @(posedge ref_clk) begin
      if (do_push) mem_reg[wr_reg] <= q.push_data;
   end
endmodule
`default_nettype wire

// ### hw/skid_buffer.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module skid_buffer #(
   parameter int WIDTH = 8
) (
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   input  wire logic             flush,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output var  logic             in_ready,
   output var  logic             out_valid,
   output var  logic [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   logic [WIDTH-1:0] d0_reg, d0_next, d1_reg, d1_next;
   logic [1:0]       cnt_reg, cnt_next;
   logic             take;
   logic             give;

   assign in_ready  = (cnt_reg != 2'h2);
   assign out_valid = (cnt_reg != 2'h0);
   assign out_data  = d0_reg;

   always_comb begin
      take     = in_valid && in_ready;
      give     = out_valid && out_ready;
      d0_next  = d0_reg;
      d1_next  = d1_reg;
      cnt_next = cnt_reg;
      if (flush) begin
         cnt_next = 2'h0;
      end else begin
         if (give) d0_next = d1_reg;
         if (take) begin
            if ((cnt_reg == 2'h0) || (cnt_reg == 2'h1 && give)) d0_next = in_data;
            else d1_next = in_data;
         end
         cnt_next = 2'(cnt_reg + take - give);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         d0_reg  <= '0;
         d1_reg  <= '0;
         cnt_reg <= 2'h0;
      end else begin
         d0_reg  <= d0_next;
         d1_reg  <= d1_next;
         cnt_reg <= cnt_next;
      end
   end
endmodule
`default_nettype wire

// ### test/radio_spi_asserts.sv
// Pin and stream checks on the serial port block
`timescale 1ns/1ps
`default_nettype none
module radio_spi_asserts
   import radio_spi_pkg::*;
(
   input wire logic       ref_clk,
   input wire logic       rst_n,
   input wire logic       chip_select_n,
   input wire logic       serial_clk,
   input wire logic       serial_data_in,
   input wire logic       gp_output_1_shared_oe,
   input wire logic       shared_pin_generic_en,
   input wire logic       pin_ctrl_en,
   input wire logic [2:0] radio_state,
   input wire logic       tx_out_valid,
   input wire logic [7:0] tx_out_data,
   input wire logic       tx_out_ready,
   input wire logic       rx_in_valid,
   input wire logic       rx_in_ready
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire logic       cs = chip_select_n;
   wire logic [2:0] st = radio_state;
   wire logic       c11 = pin_ctrl_en && serial_clk && serial_data_in;
   wire logic       c01 = pin_ctrl_en && !serial_clk && serial_data_in;
   oe_float_a: assert property ((cs && !shared_pin_generic_en)[*4] |-> !gp_output_1_shared_oe)
      else $error("shared pin driven");
   oe_drive_a: assert property ((!cs)[*5] |-> gp_output_1_shared_oe)
      else $error("shared pin floats");
   rx_cmd_a: assert property ($fell(cs) && c11 && st == CODE_IDLE |-> ##[2:8] st == CODE_RX)
      else $error("no receive");
   tx_cmd_a: assert property ($fell(cs) && c01 && st == CODE_IDLE |-> ##[2:8] st == CODE_TX)
      else $error("no transmit");
   rx_keep_a: assert property ($fell(cs) && c11 && st == CODE_RX |-> (st == CODE_RX)[*8])
      else $error("receive restarted");
   ovf_set_a: assert property (st == CODE_RX && rx_in_valid && !rx_in_ready |=> st == CODE_OVERFLOW)
      else $error("no overflow");
   ovf_keep_a: assert property (cs[*4] ##0 st == CODE_OVERFLOW |=> st == CODE_OVERFLOW)
      else $error("overflow lost");
   unf_keep_a: assert property (cs[*4] ##0 st == CODE_UNDERFLOW |=> st == CODE_UNDERFLOW)
      else $error("underflow lost");
   tx_hold_a: assert property (cs[*8] ##0 tx_out_valid && !tx_out_ready |=> $stable(tx_out_data))
      else $error("stalled byte changed");
   cover property (st == CODE_UNDERFLOW);
   cover property (st == CODE_OVERFLOW);
   cover property (tx_out_valid && tx_out_ready);
endmodule
bind radio_spi_fifo_table_pin_control radio_spi_asserts i_radio_spi_asserts (.ref_clk, .rst_n,
   .chip_select_n, .serial_clk, .serial_data_in, .gp_output_1_shared_oe, .shared_pin_generic_en,
   .pin_ctrl_en, .radio_state, .tx_out_valid, .tx_out_data, .tx_out_ready, .rx_in_valid,
   .rx_in_ready);
`default_nettype wire

// ### test/host.sv
// Host serial port master facing the block
`timescale 1ns/1ps
`default_nettype none
module host (
   input  wire logic ref_clk,
   input  wire logic miso,
   output var  logic cs_n,
   output var  logic sclk,
   output var  logic mosi
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // Released data line toggles so a stale level is never read back
   task automatic sel(input logic lvl);
      tick(1);
      cs_n <= lvl;
      mosi <= ~mosi;
      tick(4);
   endtask
   // header first, MSB first, 80 ns clock
   task automatic xfer(input logic [7:0] d, output logic [7:0] r);
      for (int i = 7; i >= 0; i--) begin
         mosi <= d[i];
         tick(4);
         sclk <= 1'b1;
         tick(1);
         r[i] = miso;
         tick(3);
         sclk <= 1'b0;
      end
   endtask
   task automatic pin_cmd(input logic c, input logic d);
      sclk <= c;
      mosi <= d;
      tick(3);
      cs_n <= 1'b0;
      tick(6);
      cs_n <= 1'b1;
      sclk <= 1'b0;
      tick(8);
   endtask
endmodule
`default_nettype wire

// ### test/test_radio_spi_fifo_table_pin_control.sv
// Self-checking bench of the serial port, queue and table block
`timescale 1ns/1ps
`default_nettype none
module test_radio_spi_fifo_table_pin_control;
   import radio_spi_pkg::*;
   logic       ref_clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       pin_ctrl_en = 1'b0;
   logic [2:0] pa_level_select = 3'h0;
   logic       tx_out_ready = 1'b0;
   logic       rx_in_valid = 1'b0;
   logic [7:0] rx_in_data = 8'h40;
   logic       tx_run = 1'b0;
   logic [7:0] tx_exp = 8'h00;
   logic [7:0] r;
   logic       acc;
   int         miscompares = 0;
   int         n_checks = 0;
   logic       gen_en = 1'b0, ser_en = 1'b0, gp0_in = 1'b0;
   wire logic  cs_n, sclk, mosi, so_out, so_oe, tx_out_valid, rx_in_ready;
   wire logic  gp0_out, gp0_oe, ser_bit;
   wire logic [2:0] radio_state;
   wire logic [7:0] pa_setting, tx_out_data;
   wire logic  so_pin = so_oe ? so_out : 1'bz;
   always #5 ref_clk = ~ref_clk;
   host i_host (.ref_clk, .miso(so_pin), .cs_n, .sclk, .mosi);
   radio_spi_fifo_table_pin_control i_radio_spi_fifo_table_pin_control (.ref_clk, .rst_n,
      .chip_select_n(cs_n), .serial_clk(sclk), .serial_data_in(mosi),
      .gp_output_1_shared_out(so_out), .gp_output_1_shared_oe(so_oe), .gp_output_0_in(gp0_in),
      .gp_output_0_out(gp0_out), .gp_output_0_oe(gp0_oe), .pin_ctrl_en,
      .shared_pin_generic_en(gen_en), .serial_mode_en(ser_en), .pa_level_select, .pa_setting,
      .radio_state, .serial_tx_bit(ser_bit),
      .tx_out_valid, .tx_out_data, .tx_out_ready, .rx_in_valid, .rx_in_data, .rx_in_ready);
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic st(input logic [2:0] s);
      chk("radio_state", {5'h0, radio_state}, {5'h0, s});
   endtask
   task automatic hdr(input logic [7:0] h);
      i_host.sel(1'b1);
      i_host.sel(1'b0);
      i_host.xfer(h, r);
   endtask
   task automatic pin(input logic c, input logic d);
      pin_ctrl_en <= 1'b1;
      i_host.pin_cmd(c, d);
      pin_ctrl_en <= 1'b0;
      @(posedge ref_clk);
   endtask
   // Transmit side stalls every other cycle
   always @(posedge ref_clk) begin
      tx_out_ready <= tx_run & ~tx_out_ready;
      if (tx_out_valid && tx_out_ready) begin
         chk("tx_byte", tx_out_data, tx_exp);
         tx_exp <= tx_exp + 8'h01;
      end
   end
   initial begin
      repeat (40000) @(posedge ref_clk);
      miscompares++;
      end_of_test();
   end
   initial begin
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      hdr(8'h7e);
      for (int i = 0; i < 9; i++) i_host.xfer(8'h10 + 8'(i), r);
      hdr(8'hfe);
      for (int i = 0; i < 8; i++) begin
         i_host.xfer(8'h00, r);
         chk("table", r, (i == 0) ? 8'h18 : 8'h10 + 8'(i));
      end
      pa_level_select <= 3'h3;
      hdr(8'h3e);
      chk("pa_setting", pa_setting, 8'h13);
      i_host.xfer(8'h5a, r);
      hdr(8'hbe);
      i_host.xfer(8'h00, r);
      chk("table_single", r, 8'h5a);
      hdr(8'h7f);
      chk("hdr_status", r, 8'h0f);
      for (int i = 0; i < 64; i++) begin
         i_host.xfer(8'(i), r);
         chk("tx_free", r, (i > 48) ? 8'(64 - i) : 8'h0f);
      end
      i_host.sel(1'b1);
      tx_run <= 1'b1;
      pin(1'b0, 1'b1);
      ser_en <= 1'b1;
      gp0_in <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk("gp0_pins", {5'h0, gp0_out, gp0_oe, ser_bit}, 8'h05);
      ser_en <= 1'b0;
      repeat (300) @(posedge ref_clk);
      tx_run <= 1'b0;
      chk("tx_count", tx_exp, 8'h40);
      st(CODE_UNDERFLOW);
      hdr(8'h31);
      i_host.sel(1'b1);
      chk("flush_status", r, 8'h7f);
      st(CODE_IDLE);
      pin(1'b1, 1'b1);
      pin(1'b1, 1'b1);
      st(CODE_RX);
      rx_in_valid <= 1'b1;
      acc = 1'b1;
      for (int i = 0; i < 80 && acc; i++) begin
         @(negedge ref_clk);
         acc = rx_in_ready;
         @(posedge ref_clk);
         rx_in_data <= rx_in_data + 8'(acc);
      end
      rx_in_valid <= 1'b0;
      repeat (2) @(posedge ref_clk);
      st(CODE_OVERFLOW);
      gen_en <= 1'b1;
      repeat (2) @(posedge ref_clk);
      chk("shared_pin", {6'h0, so_oe, so_out}, 8'h03);
      gen_en <= 1'b0;
      hdr(8'hbf);
      chk("rx_hdr", r, 8'h6f);
      i_host.xfer(8'h00, r);
      chk("rx_data", r, 8'h40);
      hdr(8'h30);
      i_host.sel(1'b1);
      st(CODE_IDLE);
      pin(1'b0, 1'b0);
      pa_level_select <= 3'h1;
      repeat (2) @(posedge ref_clk);
      chk("pa_lost", pa_setting, 8'h00);
      i_host.pin_cmd(1'b1, 1'b1);
      st(CODE_IDLE);
      end_of_test();
   end
endmodule
`default_nettype wire
